/* hdl/pmec_defs.svh */
// Bit positions, offsets and reset values for the event control block.
// Assumes inclusion by bare name from the package and the modules.
`ifndef PMEC_DEFS_SVH
`define PMEC_DEFS_SVH

// Register offsets (word addresses on the plain register port)
`define PMEC_OFF_CTRL0      4'h0
`define PMEC_OFF_CTRL2      4'h1
`define PMEC_OFF_STATUS     4'h2
`define PMEC_OFF_MASK       4'h3
`define PMEC_OFF_STATE      4'h4
`define PMEC_OFF_CNTNEG     4'h5

// Control register 0 fields, bit 31 is the most significant bit
`define PMEC_B_FREEZE       31
`define PMEC_B_EXC_EN       26
`define PMEC_B_FRZ_ON_EV    25
`define PMEC_B_TIMEBASE_BIT_SELECT_HI     24
`define PMEC_B_TIMEBASE_BIT_SELECT_LO     23
`define PMEC_B_TB_EN        22
`define PMEC_B_THR_HI       21
`define PMEC_B_THR_LO       16
`define PMEC_B_C1_EN        15
`define PMEC_B_CJ_EN        14
`define PMEC_B_TRIGGER      13
`define PMEC_CTRL0_RST      32'h0000_0000
`define PMEC_CTRL0_WMASK    32'h8fff_e000

// Control register 2: scale select in its top bit
`define PMEC_B_SCALE        31

// Time base bit positions in little-endian numbering
`define PMEC_TB_SEL0        0
`define PMEC_TB_SEL1        8
`define PMEC_TB_SEL2        12
`define PMEC_TB_SEL3        16

// Threshold scale shifts: times 2 or times 32
`define PMEC_SHIFT_X2       1
`define PMEC_SHIFT_X32      5

// Interrupt status bits
`define PMEC_ST_EVENT       0
`define PMEC_ST_EXC         1
`define PMEC_ST_FREEZE      2
`define PMEC_ST_RELEASE     3

`endif

/* hdl/pmec_pkg.sv */
// Types for the performance monitor event control block.
// Assumes pmec_defs.svh is on the include path.
`include "pmec_defs.svh"

package pmec_pkg;
    typedef logic [31:0] pmec_word_t;
    typedef logic [3:0]  pmec_addr_t;
    typedef logic [1:0]  pmec_timebase_bit_select_t;
endpackage

/* hdl/pmec_thresh.sv */
// Threshold filter for duration-type first counter events.
// Assumes event duration arrives with its qualifying strobe.
`include "pmec_defs.svh"

module pmec_thresh
#(
    parameter int DUR_W = 12
)
(
    // Clock and reset
    input  wire logic             sys_clk_in,
    input  wire logic             rst_in,
    input  wire logic             clk_en_in,
    // Threshold setting
    input  wire logic [5:0]       thresh_in,
    input  wire logic             scale_sel_in,
    // Event with measured duration
    input  wire logic             ev_in,
    input  wire logic [DUR_W-1:0] dur_in,
    // Qualified event
    output logic                  ev_out
);
    import pmec_pkg::*;

    logic [DUR_W-1:0] limit;
    logic             exceeds;
    logic             ev_ff;

    // Scaled limit: 2 or 32 times the field; narrower widths would wrap
    assign limit = scale_sel_in
        ? DUR_W'({thresh_in, 5'h00})
        : DUR_W'({thresh_in, 1'h0});
    // R9 only longer events
    assign exceeds = dur_in > limit;

    // Registered qualified event
    always_ff @(posedge sys_clk_in or posedge rst_in)
    begin
        if (rst_in)
            ev_ff <= 1'b0;
        else if (clk_en_in)
            ev_ff <= ev_in & exceeds;
    end
    assign ev_out = ev_ff;

    // R10 scale check
    a_scaled_thresh: assert property (@(posedge sys_clk_in) disable iff
        (rst_in) clk_en_in && ev_in && scale_sel_in &&
        ({2'h0, dur_in} <= {thresh_in, 8'h00} >> 3) |=> !ev_out) // R10
        else $error("event passed below x32 threshold");
endmodule

/* hdl/pmec_core.sv */
// Event control for the performance monitor: freeze, trigger, exception.
// Assumes counter MSBs and time base word arrive on the processor clock.
//
// Overview of operation
// R1 - Without freeze-on-event, events never set freeze
// R2 - Freeze-on-event sets freeze on enabled event
// R3 - Trigger set: freeze-on-event treated as zero
// R4 - Selector picks time base bit 31/23/19/15
// R5 - Enabled rising selected bit signals event
// R6 - Time base event acts as enabled event
// R7 - Edge detect after selector; may glitch
// R8 - Software uses same selector on all processors
// R9 - Threshold filters duration events
// R10 - Threshold scaled by 2 or 32
// R11 - First counter negative gated by enable
// R12 - Other counters negative gated by enable
// R13 - Counter negative conditions are enabled events
// R14 - Freeze stops all counter increments
// R15 - Trigger holds others until release
// R16 - Exception raised, exception enable cleared
// R17 - Negative means most significant bit set
`include "pmec_defs.svh"

module pmec_core
#(
    parameter int NUM_OTHER = 3,
    parameter int DUR_W     = 12
)
(
    // Clock, enable and reset
    input  wire logic                 sys_clk_in,
    input  wire logic                 rst_in,
    input  wire logic                 clk_en_in,
    // Register port
    input  wire pmec_pkg::pmec_addr_t reg_addr_in,
    input  wire pmec_pkg::pmec_word_t reg_wdata_in,
    input  wire logic                 reg_wr_in,
    input  wire logic                 reg_rd_in,
    output pmec_pkg::pmec_word_t      reg_rdata_out,
    // Counter sign bits and time base
    input  wire logic                 first_msb_in,
    input  wire logic [NUM_OTHER-1:0] other_msb_in,
    input  wire logic [31:0]          timebase_lower_word_in,
    // Duration-type first counter event
    input  wire logic                 dur_ev_in,
    input  wire logic [DUR_W-1:0]     dur_in,
    // Counter gating
    output logic                      first_count_en_out,
    output logic                      other_count_en_out,
    output logic                      dur_ev_out,
    // Monitor exception and interrupt
    output logic                      monitor_exc_out,
    output logic                      irq_out
);
    import pmec_pkg::*;

    pmec_word_t ctrl0_ff;
    logic       scale_ff;
    logic [3:0] status_ff;
    logic [3:0] mask_ff;
    logic       tb_prev_ff;
    logic       exc_ff;
    pmec_word_t rdata_ff;

    logic        tb_bit;
    logic        tb_rise;
    logic        c1_neg;
    logic        cj_neg;
    logic        enabled_ev;
    logic        do_freeze;
    logic        do_release;
    logic        do_exc;
    logic        wr_ctrl0;
    logic        wr_ctrl2;
    logic        wr_mask;
    logic        rd_status;
    logic        freeze;
    logic        trigger;
    pmec_timebase_bit_select_t timebase_bit_select;
    pmec_word_t  nxt_ctrl0;
    pmec_word_t  nxt_rdata;
    logic [3:0]  nxt_status;
    logic [3:0]  events;

    // Pick one time base bit by selector code
    function automatic logic tb_pick(input pmec_timebase_bit_select_t sel,
                                     input logic [31:0] tb);
        case (sel)
            2'h0:    tb_pick = tb[`PMEC_TB_SEL0];
            2'h1:    tb_pick = tb[`PMEC_TB_SEL1];
            2'h2:    tb_pick = tb[`PMEC_TB_SEL2];
            default: tb_pick = tb[`PMEC_TB_SEL3];
        endcase
    endfunction

    // Field views of control register 0
    assign freeze  = ctrl0_ff[`PMEC_B_FREEZE];
    assign trigger = ctrl0_ff[`PMEC_B_TRIGGER];
    assign timebase_bit_select   = ctrl0_ff[`PMEC_B_TIMEBASE_BIT_SELECT_HI:`PMEC_B_TIMEBASE_BIT_SELECT_LO];

    // R4 selector mux
    assign tb_bit = tb_pick(timebase_bit_select, timebase_lower_word_in);
    // R7 edge after the mux, so selector changes may glitch
    // R5 rising edge when enabled
    assign tb_rise = ctrl0_ff[`PMEC_B_TB_EN] & tb_bit & ~tb_prev_ff;

    // R17 sign from most significant bit
    // R11 first counter condition gate
    assign c1_neg = ctrl0_ff[`PMEC_B_C1_EN] & first_msb_in;
    // R12 other counters condition gate
    assign cj_neg = ctrl0_ff[`PMEC_B_CJ_EN] & (|other_msb_in);

    // R13 counter negative as event
    // R6 time base as event
    assign enabled_ev = c1_neg | cj_neg | tb_rise;

    // R2 freeze only with trigger clear
    // R3 trigger masks freeze-on-event
    // R1 no freeze path without the enable
    assign do_freeze  = enabled_ev & ctrl0_ff[`PMEC_B_FRZ_ON_EV]
                      & ~trigger;
    // R15 release on first negative or any enabled event
    assign do_release = trigger & (first_msb_in | enabled_ev);
    // R16 exception on enabled event
    assign do_exc     = enabled_ev & ctrl0_ff[`PMEC_B_EXC_EN];

    // Register decode
    assign wr_ctrl0  = reg_wr_in & (reg_addr_in == `PMEC_OFF_CTRL0);
    assign wr_ctrl2  = reg_wr_in & (reg_addr_in == `PMEC_OFF_CTRL2);
    assign wr_mask   = reg_wr_in & (reg_addr_in == `PMEC_OFF_MASK);
    assign rd_status = reg_rd_in & (reg_addr_in == `PMEC_OFF_STATUS);

    // Next control word: hardware updates win over software writes
    always_comb
    begin
        nxt_ctrl0 = ctrl0_ff;
        if (wr_ctrl0)
            nxt_ctrl0 = reg_wdata_in & `PMEC_CTRL0_WMASK;
        if (do_freeze)
            nxt_ctrl0[`PMEC_B_FREEZE] = 1'b1;
        if (do_release)
            nxt_ctrl0[`PMEC_B_TRIGGER] = 1'b0;
        if (do_exc)
            nxt_ctrl0[`PMEC_B_EXC_EN] = 1'b0;
    end

    // Sticky event bits; a set in the clearing read still lands
    assign events = {do_release, do_freeze, do_exc, enabled_ev};
    assign nxt_status = (rd_status ? 4'h0 : status_ff) | events;

    // Read data mux, unmapped reads return zero
    always_comb
    begin
        case (reg_addr_in)
            `PMEC_OFF_CTRL0:  nxt_rdata = ctrl0_ff;
            `PMEC_OFF_CTRL2:  nxt_rdata = {scale_ff, 31'h0};
            `PMEC_OFF_STATUS: nxt_rdata = {28'h0, status_ff};
            `PMEC_OFF_MASK:   nxt_rdata = {28'h0, mask_ff};
            `PMEC_OFF_STATE:  nxt_rdata = {29'h0, tb_prev_ff,
                                           trigger, freeze};
            `PMEC_OFF_CNTNEG: nxt_rdata = {30'h0, cj_neg, c1_neg};
            default:          nxt_rdata = 32'h0000_0000;
        endcase
    end

    // Control, status and read registers
    always_ff @(posedge sys_clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            ctrl0_ff   <= `PMEC_CTRL0_RST;
            scale_ff   <= 1'b0;
            status_ff  <= 4'h0;
            mask_ff    <= 4'h0;
            tb_prev_ff <= 1'b0;
            exc_ff     <= 1'b0;
            rdata_ff   <= 32'h0000_0000;
        end
        else if (clk_en_in)
        begin
            ctrl0_ff   <= nxt_ctrl0;
            status_ff  <= nxt_status;
            tb_prev_ff <= tb_bit;
            exc_ff     <= do_exc;
            if (wr_ctrl2)
                scale_ff <= reg_wdata_in[`PMEC_B_SCALE];
            if (wr_mask)
                mask_ff <= reg_wdata_in[3:0];
            if (reg_rd_in)
                rdata_ff <= nxt_rdata;
        end
    end

    // R14 freeze gates all counting
    // R15 others held while trigger set
    assign first_count_en_out = ~freeze;
    assign other_count_en_out = ~freeze & ~trigger;
    assign monitor_exc_out    = exc_ff;
    assign reg_rdata_out      = rdata_ff;
    assign irq_out            = |(status_ff & mask_ff);

    // R9 threshold filter on duration events
    pmec_thresh #(.DUR_W(DUR_W)) u_thresh (
        .sys_clk_in   (sys_clk_in),
        .rst_in       (rst_in),
        .clk_en_in    (clk_en_in),
        .thresh_in    (ctrl0_ff[`PMEC_B_THR_HI:`PMEC_B_THR_LO]),
        .scale_sel_in (scale_ff),
        .ev_in        (dur_ev_in),
        .dur_in       (dur_in),
        .ev_out       (dur_ev_out)
    );

    // Assertions
    a_freeze_on_event: assert property (@(posedge sys_clk_in)
        disable iff (rst_in) clk_en_in && enabled_ev && !trigger &&
        ctrl0_ff[`PMEC_B_FRZ_ON_EV] |=> freeze) // R2
        else $error("freeze not set on enabled event");
    a_no_freeze_path: assert property (@(posedge sys_clk_in)
        disable iff (rst_in) clk_en_in && !freeze && !wr_ctrl0 &&
        !ctrl0_ff[`PMEC_B_FRZ_ON_EV] |=> !freeze) // R1
        else $error("freeze set without freeze-on-event");
    a_trigger_masks: assert property (@(posedge sys_clk_in)
        disable iff (rst_in) clk_en_in && trigger && !freeze &&
        !wr_ctrl0 |=> !freeze) // R3
        else $error("freeze set while trigger active");
    a_tb_event: assert property (@(posedge sys_clk_in)
        disable iff (rst_in) clk_en_in && !wr_ctrl0 &&
        ctrl0_ff[`PMEC_B_TB_EN] && ctrl0_ff[`PMEC_B_EXC_EN] &&
        $rose(tb_bit) |=> monitor_exc_out) // R5
        else $error("time base rise gave no exception");
    a_tb_disabled: assert property (@(posedge sys_clk_in)
        disable iff (rst_in) !ctrl0_ff[`PMEC_B_TB_EN] |-> !tb_rise) // R5
        else $error("time base event while disabled");
    a_timebase_bit_select_pick: assert property (@(posedge sys_clk_in)
        disable iff (rst_in) timebase_bit_select == 2'h3 |->
        tb_bit == timebase_lower_word_in[16]) // R4
        else $error("wrong time base bit selected");
    a_c1_gate: assert property (@(posedge sys_clk_in)
        disable iff (rst_in) first_msb_in && !ctrl0_ff[`PMEC_B_C1_EN]
        && !ctrl0_ff[`PMEC_B_CJ_EN] && !ctrl0_ff[`PMEC_B_TB_EN]
        |-> !enabled_ev) // R11
        else $error("disabled first counter condition acted");
    a_cj_event: assert property (@(posedge sys_clk_in)
        disable iff (rst_in) clk_en_in && (|other_msb_in) &&
        ctrl0_ff[`PMEC_B_CJ_EN] |=> status_ff[`PMEC_ST_EVENT]) // R12
        else $error("other counter condition lost");
    a_release_trig: assert property (@(posedge sys_clk_in)
        disable iff (rst_in) clk_en_in && trigger && first_msb_in
        |=> other_count_en_out == !freeze) // R15
        else $error("trigger not released");
    a_exc_clears: assert property (@(posedge sys_clk_in)
        disable iff (rst_in) clk_en_in && do_exc |=>
        !ctrl0_ff[`PMEC_B_EXC_EN] && monitor_exc_out) // R16
        else $error("exception enable not cleared");
    a_freeze_holds: assert property (@(posedge sys_clk_in)
        disable iff (rst_in) freeze |-> !first_count_en_out &&
        !other_count_en_out) // R14
        else $error("counting while frozen");
endmodule

/* test/tb_top.sv */
// Self-checking bench for the performance monitor event control core.
// Assumes pmec_pkg and pmec_defs.svh are compiled ahead of this file.
`include "pmec_defs.svh"

module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import pmec_pkg::*;

    typedef struct packed {
        pmec_word_t cfg;
        logic       f;
        logic [2:0] o;
        int         exc;
        pmec_word_t res;
    } pmec_row_t;

    // Control word, counter signs, exception pulses, then expected control word after
    pmec_row_t rows [9] = '{
        '{32'h0200_8000, 1'b1, 3'h0, 0, 32'h8200_8000},
        '{32'h0000_8000, 1'b1, 3'h0, 0, 32'h0000_8000},
        '{32'h0200_0000, 1'b1, 3'h0, 0, 32'h0200_0000},
        '{32'h0200_4000, 1'b0, 3'h2, 0, 32'h8200_4000},
        '{32'h0200_8000, 1'b0, 3'h4, 0, 32'h0200_8000},
        '{32'h0200_a000, 1'b1, 3'h0, 0, 32'h0200_8000},
        '{32'h0000_6000, 1'b0, 3'h1, 0, 32'h0000_4000},
        '{32'h0400_8000, 1'b1, 3'h0, 1, 32'h0000_8000},
        '{32'h0000_2000, 1'b1, 3'h0, 0, 32'h0000_0000}};
    int doc_bit [4] = '{31, 23, 19, 15};

    logic        sys_clk_in;
    logic        rst_in;
    logic        clk_en;
    pmec_addr_t  reg_addr_in;
    pmec_word_t  reg_wdata_in;
    logic        reg_wr_in;
    logic        reg_rd_in;
    pmec_word_t  reg_rdata_out;
    logic        first_msb_in;
    logic [2:0]  other_msb_in;
    pmec_word_t  tb_word;
    logic        dur_ev_in;
    logic [11:0] dur_in;
    logic        first_en;
    logic        other_en;
    logic        dur_ev;
    logic        exc;
    logic        irq;
    pmec_word_t  d;
    int          errors;
    int          checks;
    int          exc_cnt;
    int          n;

    pmec_core #(.NUM_OTHER(3), .DUR_W(12)) dut (
        .sys_clk_in             (sys_clk_in),
        .rst_in                 (rst_in),
        .clk_en_in              (clk_en),
        .reg_addr_in            (reg_addr_in),
        .reg_wdata_in           (reg_wdata_in),
        .reg_wr_in              (reg_wr_in),
        .reg_rd_in              (reg_rd_in),
        .reg_rdata_out          (reg_rdata_out),
        .first_msb_in           (first_msb_in),
        .other_msb_in           (other_msb_in),
        .timebase_lower_word_in (tb_word),
        .dur_ev_in              (dur_ev_in),
        .dur_in                 (dur_in),
        .first_count_en_out     (first_en),
        .other_count_en_out     (other_en),
        .dur_ev_out             (dur_ev),
        .monitor_exc_out        (exc),
        .irq_out                (irq)
    );

    // 25 MHz clock
    initial
    begin
        sys_clk_in = 1'b0;
        forever #20 sys_clk_in = ~sys_clk_in;
    end

    // Exception pulses counted mid-cycle, so latency need not be exact
    always @(negedge sys_clk_in)
        if (exc === 1'b1) exc_cnt <= exc_cnt + 1;

    // Watchdog: the whole sequence needs well under 1000 cycles
    initial
    begin
        #40000;
        errors = errors + 1;
        end_of_test();
    end

    task automatic chk(input pmec_word_t seen, input pmec_word_t exp);
        checks = checks + 1;
        if (seen !== exp)
        begin
            errors = errors + 1;
            $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask

    // Bus tasks start and end just after a rising edge
    task automatic wr(input pmec_addr_t a, input pmec_word_t v);
        reg_addr_in <= a;
        reg_wdata_in <= v;
        reg_wr_in <= 1'b1;
        @(posedge sys_clk_in);
        reg_wr_in <= 1'b0;
    endtask

    task automatic rd(input pmec_addr_t a, output pmec_word_t v);
        reg_addr_in <= a;
        reg_rd_in <= 1'b1;
        @(posedge sys_clk_in);
        reg_rd_in <= 1'b0;
        #1 v = reg_rdata_out;
        @(posedge sys_clk_in);
    endtask

    task automatic settle();
        @(posedge sys_clk_in);
        @(negedge sys_clk_in);
    endtask

    task automatic end_of_test();
        if (errors == 0 && checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    initial
    begin
        errors = 0;
        checks = 0;
        exc_cnt = 0;
        clk_en = 1'b1;
        rst_in = 1'b1;
        {reg_addr_in, reg_wdata_in, reg_wr_in, reg_rd_in} = '0;
        {first_msb_in, other_msb_in, tb_word, dur_ev_in, dur_in} = '0;
        repeat (4) @(posedge sys_clk_in);
        rst_in <= 1'b0;
        @(negedge sys_clk_in);
        chk(first_en, 1'b1);
        chk(other_en, 1'b1);
        chk(irq, 1'b0);
        @(posedge sys_clk_in);
        rd(`PMEC_OFF_CTRL0, d);
        chk(d, 32'h0);
        // Counter sign conditions against nine control combinations
        foreach (rows[i])
        begin
            n = exc_cnt;
            wr(`PMEC_OFF_CTRL0, rows[i].cfg);
            first_msb_in <= rows[i].f;
            other_msb_in <= rows[i].o;
            @(posedge sys_clk_in);
            first_msb_in <= 1'b0;
            other_msb_in <= '0;
            @(negedge sys_clk_in);
            chk(first_en, !rows[i].res[31]);
            chk(other_en, !rows[i].res[31] && !rows[i].res[13]);
            @(posedge sys_clk_in);
            rd(`PMEC_OFF_CTRL0, d);
            chk(d, rows[i].res);
            rd(`PMEC_OFF_STATUS, d);
            chk(exc_cnt - n, rows[i].exc);
        end
        // Each selector code watches only its own time base bit
        // one selector value held through each pass, as across processors
        for (int c = 0; c < 4; c++)
        begin
            wr(`PMEC_OFF_CTRL0, 32'h0240_0000 | (c << 23));
            tb_word <= ~(32'h1 << (31 - doc_bit[c]));
            settle();
            chk(first_en, 1'b1);
            @(posedge sys_clk_in);
            tb_word <= '1;
            settle();
            chk(first_en, 1'b0);
            @(posedge sys_clk_in);
            wr(`PMEC_OFF_CTRL0, 32'h0);
            tb_word <= '0;
            rd(`PMEC_OFF_STATUS, d);
        end
        // Rise ignored while the time base event is disabled
        wr(`PMEC_OFF_CTRL0, 32'h0200_0000);
        tb_word <= '1;
        settle();
        chk(first_en, 1'b1);
        // Selector change alone produces a rise on its output
        @(posedge sys_clk_in);
        tb_word <= 32'h0000_0100;
        wr(`PMEC_OFF_CTRL0, 32'h0240_0000);
        settle();
        chk(first_en, 1'b1);
        @(posedge sys_clk_in);
        wr(`PMEC_OFF_CTRL0, 32'h02c0_0000);
        settle();
        chk(first_en, 1'b0);
        @(posedge sys_clk_in);
        wr(`PMEC_OFF_CTRL0, 32'h0);
        tb_word <= '0;
        rd(`PMEC_OFF_STATUS, d);
        // Interrupt: masked first, then unmasked, then read-cleared
        wr(`PMEC_OFF_MASK, 32'h0);
        wr(`PMEC_OFF_CTRL0, 32'h0000_8000);
        first_msb_in <= 1'b1;
        @(posedge sys_clk_in);
        first_msb_in <= 1'b0;
        settle();
        chk(irq, 1'b0);
        @(posedge sys_clk_in);
        wr(`PMEC_OFF_MASK, 32'h1);
        @(negedge sys_clk_in);
        chk(irq, 1'b1);
        @(posedge sys_clk_in);
        rd(`PMEC_OFF_STATUS, d);
        chk(d, 32'h1);
        chk(irq, 1'b0);
        // Threshold 3 scaled to 6 then 96, strict compare at the edges
        wr(`PMEC_OFF_CTRL0, 32'h0003_0000);
        for (int k = 0; k < 4; k++)
        begin
            wr(`PMEC_OFF_CTRL2, {k[1], 31'h0});
            dur_ev_in <= 1'b1;
            dur_in <= (k[1] ? 12'd96 : 12'd6) + 12'(k[0]);
            @(posedge sys_clk_in);
            dur_ev_in <= 1'b0;
            @(negedge sys_clk_in);
            chk(dur_ev, k[0]);
            @(posedge sys_clk_in);
        end
        // Clock enable low: a negative counter must not freeze
        wr(`PMEC_OFF_CTRL0, 32'h0200_8000);
        clk_en <= 1'b0;
        first_msb_in <= 1'b1;
        @(posedge sys_clk_in);
        clk_en <= 1'b1;
        first_msb_in <= 1'b0;
        @(negedge sys_clk_in);
        chk(first_en, 1'b1);
        @(posedge sys_clk_in);
        rd(`PMEC_OFF_CTRL0, d);
        chk(d, 32'h0200_8000);
        // Unmapped place, write mask, then a reset in mid-run
        wr(4'hf, '1);
        rd(4'hf, d);
        chk(d, 32'h0);
        wr(`PMEC_OFF_CTRL0, '1);
        rd(`PMEC_OFF_CTRL0, d);
        chk(d, 32'h8fff_e000);
        rst_in <= 1'b1;
        @(negedge sys_clk_in);
        chk(first_en, 1'b1);
        @(posedge sys_clk_in);
        rst_in <= 1'b0;
        @(posedge sys_clk_in);
        rd(`PMEC_OFF_CTRL0, d);
        chk(d, 32'h0);
        end_of_test();
    end
endmodule
